// file: rtl/fbc_crc_byte.sv
`timescale 1ns/1ps
// one byte through the x^16+x^12+x^5+1 checksum, selectable bit order
module fbc_crc_byte (
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data,
    input  wire logic        msb_first,
    output logic      [15:0] crc_out
);
    always_comb begin
        logic [15:0] c;
        logic        fb;
        c = crc_in;
        fb = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (msb_first) begin
                fb = c[15] ^ data[7 - i];
                c  = {c[14:0], 1'b0} ^ (fb ? fbc_pkg::CRC_POLY : 16'h0000);
            end else begin
                // reflected form of the same polynomial
                fb = c[0] ^ data[i];
                c  = {1'b0, c[15:1]} ^ (fb ? 16'h8408 : 16'h0000);
            end
        end
        crc_out = c;
    end
endmodule : fbc_crc_byte

// file: rtl/fbc_fifo_crc.sv
`timescale 1ns/1ps
module fbc_fifo_crc #(
    parameter int DEPTH  = 64,
    parameter int DATA_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,
    input  wire logic              eng_wr,
    input  wire logic [DATA_W-1:0] eng_wdata,
    input  wire logic              eng_rd,
    output logic      [DATA_W-1:0] eng_rdata,
    output logic                   eng_empty,
    output logic                   eng_full,
    output logic                   irq
);
    // ************************************************************
    // parameter checks
    // ************************************************************
    // pointers wrap by overflow, and the count needs one bit more
    localparam int PTR_W = $clog2(DEPTH);
    if (DEPTH != 64 || DATA_W != 8) begin : g_bad_size
        $error("fbc_fifo_crc: only 64 x 8 is supported");
    end

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {
        FBC_IDLE = 2'b01,
        FBC_RUN  = 2'b10
    } fbc_crc_state_type;

    // one packed word holds every flop of the block except storage
    typedef struct packed {
        logic [PTR_W-1:0]  wr_ptr;
        logic [PTR_W-1:0]  rd_ptr;
        logic [PTR_W:0]    count;
        logic              overrun;
        logic [5:0]        thresh;
        logic              empty_ie;
        logic              full_ie;
        logic              empty_irq;
        logic              full_irq;
        logic              empty_prev;
        logic              full_prev;
        logic [1:0]        preset_sel;
        logic              msb_first;
        logic [15:0]       crc;
        logic              crc_ready;
        logic              crc_irq;
        fbc_crc_state_type crc_state;
        logic [31:0]       rdata;
        logic [DATA_W-1:0] eng_rdata;
    } fbc_state_type;

    fbc_state_type     st;
    fbc_state_type     next_st;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [15:0]       crc_step;
    logic [15:0]       preset;
    logic              empty_stat;
    logic              full_stat;
    logic              acc;
    logic              wr_acc;
    logic              rd_acc;
    logic              push;
    logic              pop;
    logic [DATA_W-1:0] push_data;
    logic [DATA_W-1:0] head;

    // storage is read combinationally at the read pointer
    assign head = mem[st.rd_ptr];

    fbc_crc_byte u_crc (
        .crc_in    (st.crc),
        .data      (head),
        .msb_first (st.msb_first),
        .crc_out   (crc_step)
    );

    // ************************************************************
    // combinational status
    // ************************************************************
    assign acc        = psel && penable;
    assign wr_acc     = acc && pwrite;
    assign rd_acc     = acc && !pwrite;
    // every access completes at once: no wait state is inserted
    assign pready     = 1'b1;
    assign pslverr    = 1'b0;
    assign prdata     = st.rdata;
    assign eng_rdata  = st.eng_rdata;
    // engine status flags decode the count directly
    assign eng_empty  = (st.count == '0);
    assign eng_full   = (st.count == (PTR_W + 1)'(DEPTH));
    assign full_stat  = ((PTR_W + 1)'(DEPTH) - st.count) <=
                        {1'b0, st.thresh};
    assign empty_stat = st.count <= {1'b0, st.thresh};
    // level output: it stays high until software clears the flag or its enable bit
    assign irq        = (st.empty_irq && st.empty_ie) ||
                        (st.full_irq && st.full_ie);

    always_comb begin
        // all four codes are legal, so the case needs no default
        unique case (st.preset_sel)
            2'b00: preset = fbc_pkg::PRESET_0;
            2'b01: preset = fbc_pkg::PRESET_1;
            2'b10: preset = fbc_pkg::PRESET_2;
            2'b11: preset = fbc_pkg::PRESET_3;
        endcase
    end

    // ************************************************************
    // buffer storage
    // ************************************************************
    always_comb begin
        push      = 1'b0;
        push_data = eng_wdata;
        if (wr_acc && paddr == fbc_pkg::ADDR_DATA) begin
            push      = 1'b1;
            push_data = pwdata[DATA_W-1:0];
        end else if (eng_wr) begin
            push = 1'b1;
        end
    end

    // storage has no reset: a clear moves only the pointers, so old
    // bytes become unreachable without a wide reset tree
    always_ff @(posedge clk) begin
        if (push && !eng_full) begin
            mem[st.wr_ptr] <= push_data;
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic clear;
        logic start;
        next_st = st;
        clear   = wr_acc && paddr == fbc_pkg::ADDR_FILL &&
                  pwdata[fbc_pkg::FILL_CLEAR_BIT];
        start   = wr_acc && paddr == fbc_pkg::ADDR_CRC_CMD &&
                  pwdata[fbc_pkg::CMD_START_BIT];
        pop     = 1'b0;

        // ************************************************************
        // host and engine reads; checksum unit also drains the buffer
        // ************************************************************
        // the host wins a tie, then the engine; a byte lost in a tie goes
        // to the winner and never enters the checksum
        if (rd_acc && paddr == fbc_pkg::ADDR_DATA && !eng_empty) begin
            pop = 1'b1;
        end else if (eng_rd && !eng_empty) begin
            pop               = 1'b1;
            next_st.eng_rdata = head;
        end else if (st.crc_state == FBC_RUN && !eng_empty) begin
            pop         = 1'b1;
            next_st.crc = crc_step;
        end

        // ************************************************************
        // read data decode
        // ************************************************************
        // decoded every cycle; the value loaded as the setup cycle ends
        // is what the bus master takes in the access cycle
        next_st.rdata = 32'h0000_0000;
        unique case (paddr)
            fbc_pkg::ADDR_DATA:
                next_st.rdata[DATA_W-1:0] = eng_empty ? '0 : head;
            fbc_pkg::ADDR_FILL:
                next_st.rdata[PTR_W:0] = st.count;
            fbc_pkg::ADDR_ERROR:
                next_st.rdata[fbc_pkg::ERR_OVERRUN_BIT] = st.overrun;
            fbc_pkg::ADDR_STATUS: begin
                next_st.rdata[fbc_pkg::STAT_EMPTY_BIT]   = empty_stat;
                next_st.rdata[fbc_pkg::STAT_FULL_BIT]    = full_stat;
                next_st.rdata[fbc_pkg::STAT_CRC_RDY_BIT] = st.crc_ready;
            end
            fbc_pkg::ADDR_THRESH:
                next_st.rdata[fbc_pkg::THRESH_W-1:0] = st.thresh;
            fbc_pkg::ADDR_IRQ_EN: begin
                next_st.rdata[fbc_pkg::IRQ_EMPTY_BIT] = st.empty_ie;
                next_st.rdata[fbc_pkg::IRQ_FULL_BIT]  = st.full_ie;
            end
            fbc_pkg::ADDR_IRQ: begin
                next_st.rdata[fbc_pkg::IRQ_EMPTY_BIT] = st.empty_irq;
                next_st.rdata[fbc_pkg::IRQ_FULL_BIT]  = st.full_irq;
            end
            fbc_pkg::ADDR_MODE: begin
                next_st.rdata[fbc_pkg::MODE_ORDER_BIT] = st.msb_first;
                next_st.rdata[1:0]                     = st.preset_sel;
            end
            fbc_pkg::ADDR_MISC_IRQ:
                next_st.rdata[fbc_pkg::MISC_CRC_BIT] = st.crc_irq;
            fbc_pkg::ADDR_CRC_HI:
                next_st.rdata[7:0] = st.crc[15:8];
            fbc_pkg::ADDR_CRC_LO:
                next_st.rdata[7:0] = st.crc[7:0];
            default: ;
        endcase

        // ************************************************************
        // pointer and count update
        // ************************************************************
        // a refused byte never reaches storage, so the bytes already held
        // stay intact for software to drain
        // an accepted push and a pop in one cycle leave the count alone
        if (push && !eng_full) begin
            next_st.wr_ptr = st.wr_ptr + 1'b1;
        end else if (push) begin
            next_st.overrun = 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
        end
        if ((push && !eng_full) && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (!(push && !eng_full) && pop) begin
            next_st.count = st.count - 1'b1;
        end

        // ************************************************************
        // configuration writes; flags are write-one-to-clear
        // ************************************************************
        if (wr_acc) begin
            unique case (paddr)
                fbc_pkg::ADDR_THRESH:
                    next_st.thresh = pwdata[fbc_pkg::THRESH_W-1:0];
                fbc_pkg::ADDR_IRQ_EN: begin
                    next_st.empty_ie = pwdata[fbc_pkg::IRQ_EMPTY_BIT];
                    next_st.full_ie  = pwdata[fbc_pkg::IRQ_FULL_BIT];
                end
                fbc_pkg::ADDR_IRQ: begin
                    if (pwdata[fbc_pkg::IRQ_EMPTY_BIT]) begin
                        next_st.empty_irq = 1'b0;
                    end
                    if (pwdata[fbc_pkg::IRQ_FULL_BIT]) begin
                        next_st.full_irq = 1'b0;
                    end
                end
                fbc_pkg::ADDR_MODE: begin
                    next_st.msb_first  = pwdata[fbc_pkg::MODE_ORDER_BIT];
                    next_st.preset_sel = pwdata[1:0];
                end
                fbc_pkg::ADDR_MISC_IRQ:
                    if (pwdata[fbc_pkg::MISC_CRC_BIT]) begin
                        next_st.crc_irq = 1'b0;
                    end
                default: ;
            endcase
        end

        // ************************************************************
        // alert edges: a set in the same cycle beats a clear
        // ************************************************************
        // the empty detector starts high so that reset raises no flag
        next_st.empty_prev = empty_stat;
        next_st.full_prev  = full_stat;
        if (empty_stat && !st.empty_prev) begin
            next_st.empty_irq = 1'b1;
        end
        if (full_stat && !st.full_prev) begin
            next_st.full_irq = 1'b1;
        end

        // ************************************************************
        // checksum sequencer
        // ************************************************************
        // a start while a run is busy is ignored
        unique case (st.crc_state)
            FBC_IDLE: begin
                if (start) begin
                    next_st.crc       = preset;
                    next_st.crc_ready = 1'b0;
                    next_st.crc_state = FBC_RUN;
                end
            end
            FBC_RUN: begin
                if (eng_empty) begin
                    next_st.crc_ready = 1'b1;
                    next_st.crc_irq   = 1'b1;
                    next_st.crc_state = FBC_IDLE;
                end
            end
        endcase

        // ************************************************************
        // clear wins over anything else on pointers and overrun
        // ************************************************************
        // a push in the clear cycle is lost on purpose: software asked
        // for an empty buffer
        if (clear) begin
            next_st.wr_ptr  = '0;
            next_st.rd_ptr  = '0;
            next_st.count   = '0;
            next_st.overrun = 1'b0;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st            <= '0;
            st.thresh     <= fbc_pkg::THRESH_RESET;
            st.empty_prev <= 1'b1;
            st.crc_state  <= FBC_IDLE;
        end else begin
            st <= next_st;
        end
    end

endmodule : fbc_fifo_crc

// file: rtl/fbc_pkg.sv
package fbc_pkg;

    // ************************************************************
    // register map (byte addresses on the APB)
    // ************************************************************
    localparam logic [7:0] ADDR_DATA      = 8'h00;
    localparam logic [7:0] ADDR_FILL      = 8'h04;
    localparam logic [7:0] ADDR_ERROR     = 8'h08;
    localparam logic [7:0] ADDR_STATUS    = 8'h0C;
    localparam logic [7:0] ADDR_THRESH    = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h14;
    localparam logic [7:0] ADDR_IRQ       = 8'h18;
    localparam logic [7:0] ADDR_MODE      = 8'h1C;
    localparam logic [7:0] ADDR_MISC_IRQ  = 8'h20;
    localparam logic [7:0] ADDR_CRC_HI    = 8'h24;
    localparam logic [7:0] ADDR_CRC_LO    = 8'h28;
    localparam logic [7:0] ADDR_CRC_CMD   = 8'h2C;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int FILL_CLEAR_BIT   = 7;
    localparam int ERR_OVERRUN_BIT  = 4;
    localparam int STAT_EMPTY_BIT   = 0;
    localparam int STAT_FULL_BIT    = 1;
    localparam int STAT_CRC_RDY_BIT = 5;
    localparam int IRQ_EMPTY_BIT    = 2;
    localparam int IRQ_FULL_BIT     = 3;
    localparam int MODE_ORDER_BIT   = 7;
    localparam int MISC_CRC_BIT     = 2;
    localparam int CMD_START_BIT    = 0;
    localparam int THRESH_W         = 6;

    // ************************************************************
    // checksum constants
    // ************************************************************
    localparam logic [15:0] CRC_POLY     = 16'h1021;
    localparam logic [15:0] PRESET_0     = 16'h0000;
    localparam logic [15:0] PRESET_1     = 16'h6363;
    localparam logic [15:0] PRESET_2     = 16'hA671;
    localparam logic [15:0] PRESET_3     = 16'hFFFF;
    localparam logic [5:0]  THRESH_RESET = 6'h08;

endpackage : fbc_pkg

// file: test/fbc_eng_model.sv
`timescale 1ns/1ps
// ****************************************
// command engine side of the buffer
// ****************************************
module fbc_eng_model (
    input  wire logic       clk,
    output logic            eng_wr,
    output logic      [7:0] eng_wdata,
    output logic            eng_rd,
    input  wire logic [7:0] eng_rdata
);
    initial begin
        eng_wr = 1'b0;
        eng_rd = 1'b0;
        eng_wdata = 8'h00;
    end
    // one byte per call; data inverted when idle so stale values never match
    task automatic push(input logic [7:0] b);
        @(posedge clk);
        eng_wr <= 1'b1;
        eng_wdata <= b;
        @(posedge clk);
        eng_wr <= 1'b0;
        eng_wdata <= ~b;
    endtask : push
    task automatic pop(output logic [7:0] b);
        @(posedge clk);
        eng_rd <= 1'b1;
        @(posedge clk);
        eng_rd <= 1'b0;
        // the byte is registered at the pop edge, so take it one edge on
        @(posedge clk);
        b = eng_rdata;
    endtask : pop
endmodule : fbc_eng_model

// file: test/fbc_fifo_crc_sva.sv
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module fbc_fifo_crc_sva #(
    parameter int DEPTH  = 64,
    parameter int DATA_W = 8
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              eng_wr,
    input wire logic [DATA_W-1:0] eng_wdata,
    input wire logic              eng_rd,
    input wire logic [DATA_W-1:0] eng_rdata,
    input wire logic              eng_empty,
    input wire logic              eng_full,
    input wire logic              irq
);
    logic acc_w;
    logic acc_r;
    assign acc_w = psel && penable && pwrite;
    assign acc_r = psel && penable && !pwrite;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_zero_wait:
        assert property (psel && penable |-> pready && !pslverr)
        else $error("access not answered at once");
    a_clear_empties:
        assert property (acc_w && paddr == fbc_pkg::ADDR_FILL
            && pwdata[fbc_pkg::FILL_CLEAR_BIT] |=> eng_empty && !eng_full)
        else $error("clear left bytes stored");
    a_host_push:
        assert property (acc_w && paddr == fbc_pkg::ADDR_DATA && !eng_full
            && !eng_rd |=> !eng_empty)
        else $error("host byte not stored");
    a_engine_push:
        assert property (eng_wr && !eng_full && !eng_rd && !psel
            |=> !eng_empty)
        else $error("engine byte not stored");
    a_empty_read:
        assert property (acc_r && paddr == fbc_pkg::ADDR_DATA && eng_empty
            |=> prdata == 32'h0)
        else $error("read of empty buffer not zero");
    a_level_full:
        assert property (acc_r && paddr == fbc_pkg::ADDR_FILL && eng_full
            |=> prdata[6:0] == 7'(DEPTH))
        else $error("full level wrong");
    a_full_alert:
        assert property (acc_r && paddr == fbc_pkg::ADDR_STATUS && eng_full
            |=> prdata[1] && !prdata[0])
        else $error("alerts wrong when full");
    a_empty_alert:
        assert property (acc_r && paddr == fbc_pkg::ADDR_STATUS && eng_empty
            |=> prdata[0] && !prdata[1])
        else $error("alerts wrong when empty");
    a_irq_masked:
        assert property (acc_w && paddr == fbc_pkg::ADDR_IRQ_EN
            && pwdata[3:2] == 2'h0 |=> !irq)
        else $error("masked request still high");

    c_full: cover property (eng_full);
    c_irq: cover property ($rose(irq));
    c_clear: cover property (acc_w && paddr == fbc_pkg::ADDR_FILL);
endmodule : fbc_fifo_crc_sva

bind fbc_fifo_crc fbc_fifo_crc_sva #(.DEPTH(DEPTH), .DATA_W(DATA_W)) i_sva (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .eng_wr(eng_wr), .eng_wdata(eng_wdata),
    .eng_rd(eng_rd), .eng_rdata(eng_rdata), .eng_empty(eng_empty),
    .eng_full(eng_full), .irq(irq));

// file: test/tb_fbc_fifo_crc.sv
`timescale 1ns/1ps
module tb_fbc_fifo_crc;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        eng_wr;
    logic [7:0]  eng_wdata;
    logic        eng_rd;
    logic [7:0]  eng_rdata;
    logic        eng_empty;
    logic        eng_full;
    logic        irq;
    logic [31:0] q;
    logic [7:0]  b;
    logic [15:0] c;
    logic [15:0] pre [4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};
    int          fail_count;
    int          comparisons;
    int          cycles;

    fbc_fifo_crc i_dut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .eng_wr(eng_wr), .eng_wdata(eng_wdata), .eng_rd(eng_rd),
        .eng_rdata(eng_rdata), .eng_empty(eng_empty), .eng_full(eng_full),
        .irq(irq));
    fbc_eng_model i_eng (.clk(clk), .eng_wr(eng_wr), .eng_wdata(eng_wdata),
        .eng_rd(eng_rd), .eng_rdata(eng_rdata));

    // ****************************************
    // bus tasks and checks
    // ****************************************
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // read data is taken at the edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input string n);
        apb(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask : rc
    task automatic crc_run(input logic [7:0] mode);
        wr(fbc_pkg::ADDR_MODE, {24'h0, mode});
        wr(fbc_pkg::ADDR_CRC_CMD, 32'h1);
        repeat (30) begin
            apb(1'b0, fbc_pkg::ADDR_STATUS, 32'h0);
            if (q[5] === 1'b1)
                break;
        end
    endtask : crc_run
    function automatic logic [15:0] crc_ref(input logic [15:0] v,
                                            input logic [7:0] d,
                                            input logic m);
        for (int i = 0; i < 8; i++) begin
            if (m)
                v = {v[14:0], 1'b0} ^ ((v[15] ^ d[7-i]) ? 16'h1021 : 16'h0);
            else
                v = (v >> 1) ^ ((v[0] ^ d[i]) ? 16'h8408 : 16'h0);
        end
        return v;
    endfunction : crc_ref

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rc(fbc_pkg::ADDR_FILL, 32'h0, "fill");
        rc(fbc_pkg::ADDR_THRESH, 32'h8, "thresh");
        rc(fbc_pkg::ADDR_STATUS, 32'h1, "status");
        rc(8'h30, 32'h0, "unmapped");
        $display("test reset done");
        wr(fbc_pkg::ADDR_IRQ_EN, 32'hC);
        for (int i = 0; i < 64; i++)
            wr(fbc_pkg::ADDR_DATA, i);
        rc(fbc_pkg::ADDR_FILL, 32'h40, "fill");
        rc(fbc_pkg::ADDR_STATUS, 32'h2, "status");
        rc(fbc_pkg::ADDR_IRQ, 32'h8, "irq flags");
        chk("irq", 32'h1, {31'h0, irq});
        wr(fbc_pkg::ADDR_DATA, 32'hFF);
        rc(fbc_pkg::ADDR_ERROR, 32'h10, "error");
        rc(fbc_pkg::ADDR_FILL, 32'h40, "fill");
        rc(fbc_pkg::ADDR_DATA, 32'h0, "data");
        rc(fbc_pkg::ADDR_DATA, 32'h1, "data");
        rc(fbc_pkg::ADDR_FILL, 32'h3E, "fill");
        rc(fbc_pkg::ADDR_ERROR, 32'h10, "error");
        wr(fbc_pkg::ADDR_IRQ, 32'h8);
        @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(fbc_pkg::ADDR_FILL, 32'h80);
        rc(fbc_pkg::ADDR_FILL, 32'h0, "fill");
        rc(fbc_pkg::ADDR_ERROR, 32'h0, "error");
        rc(fbc_pkg::ADDR_DATA, 32'h0, "data");
        rc(fbc_pkg::ADDR_IRQ, 32'h4, "irq flags");
        chk("irq", 32'h1, {31'h0, irq});
        wr(fbc_pkg::ADDR_IRQ_EN, 32'h0);
        @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(fbc_pkg::ADDR_IRQ, 32'h4);
        rc(fbc_pkg::ADDR_IRQ, 32'h0, "irq flags");
        $display("test fill done");
        wr(fbc_pkg::ADDR_THRESH, 32'h2);
        for (int i = 0; i < 3; i++)
            wr(fbc_pkg::ADDR_DATA, 32'h55);
        rc(fbc_pkg::ADDR_STATUS, 32'h0, "status");
        rc(fbc_pkg::ADDR_DATA, 32'h55, "data");
        rc(fbc_pkg::ADDR_STATUS, 32'h1, "status");
        wr(fbc_pkg::ADDR_FILL, 32'h80);
        $display("test threshold done");
        // host keeps off the data port while the engine works it
        i_eng.push(8'hA5);
        i_eng.push(8'h3C);
        rc(fbc_pkg::ADDR_DATA, 32'hA5, "data");
        rc(fbc_pkg::ADDR_DATA, 32'h3C, "data");
        wr(fbc_pkg::ADDR_DATA, 32'h5A);
        i_eng.pop(b);
        chk("engine data", 32'h5A, {24'h0, b});
        $display("test engine done");
        for (int p = 0; p < 4; p++) begin
            crc_run(p[7:0]);
            rc(fbc_pkg::ADDR_CRC_HI, pre[p][15:8], "crc hi");
            rc(fbc_pkg::ADDR_CRC_LO, pre[p][7:0], "crc lo");
        end
        wr(fbc_pkg::ADDR_MISC_IRQ, 32'h4);
        for (int m = 0; m < 2; m++) begin
            wr(fbc_pkg::ADDR_DATA, 32'h12);
            wr(fbc_pkg::ADDR_DATA, 32'h34);
            crc_run(m ? 8'h83 : 8'h01);
            c = crc_ref(crc_ref(pre[m ? 3 : 1], 8'h12, m[0]), 8'h34, m[0]);
            chk("crc ready", 32'h1, {31'h0, q[5]});
            rc(fbc_pkg::ADDR_CRC_HI, c[15:8], "crc hi");
            rc(fbc_pkg::ADDR_CRC_LO, c[7:0], "crc lo");
            rc(fbc_pkg::ADDR_FILL, 32'h0, "fill");
            rc(fbc_pkg::ADDR_MISC_IRQ, 32'h4, "crc done");
            wr(fbc_pkg::ADDR_MISC_IRQ, 32'h4);
        end
        $display("test checksum done");
        wrap_up();
    end
endmodule : tb_fbc_fifo_crc
